// ===== inc/xpt_decoder_pkg.sv
// Shared constants, field layouts and carrier types for the crosspoint bitstream decoder.
// Assumes one system clock domain for the register port and one serial link clock domain.
package xpt_decoder_pkg;

  // ----------------------------------------
  // Framing and decode constants
  // ----------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int OUT_COUNT = 16;
  localparam int CHIP_COUNT = 6;
  localparam logic [2:0] BITPOS_LAST = 3'h7;
  localparam logic [2:0] BITPOS_INDEX_STEP = 3'h2;
  localparam logic [2:0] BITPOS_RESET = 3'h0;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic [1:0] GROUP_OFF = 2'h3;
  localparam logic [1:0] SLOT_LIMIT = 2'h2;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LAST_OFFSET = 8'h08;
  localparam logic [7:0] ROUTE_BASE = 8'h40;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_SLOT_LSB = 0;
  localparam int STATUS_LEGAL_BIT = 2;
  localparam int STATUS_COUNT_LSB = 8;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] slot;
    logic [1:0] group;
    logic [3:0] input_num;
  } control_byte_t;

  typedef struct packed {
    logic [5:0] tsel;
    logic [2:0] addr;
  } route_entry_t;

  typedef struct packed {
    logic [3:0] index;
    route_entry_t entry;
  } load_word_t;

  localparam route_entry_t ROUTE_RESET = '{tsel: 6'h00, addr: 3'h0};

  // Byte plus card identity to chip selects and chip input address
  function automatic route_entry_t decode_route(control_byte_t b, logic [1:0] id);
    route_entry_t r;
    logic [2:0] chip;
    r = ROUTE_RESET;
    chip = {b.group, b.input_num[3]};
    r.addr = b.input_num[2:0];
    if ((b.slot == id) && (id <= SLOT_LIMIT) && (b.group != GROUP_OFF)) begin
      r.tsel = 6'(6'h01 << chip);
    end
    return r;
  endfunction : decode_route

endpackage : xpt_decoder_pkg

// ===== rtl/crosspoint_bitstream_decoder.sv
// Serial control bitstream decoder for a 48-input by 16-output crosspoint card.
// Assumes the serial clock, data and strobe come from one far-end source on the
// link clock, and that the link clock gives at least one edge with the strobe low
// between frames.
//
// Contract
// - Shift serial data only on link clock edges while the strobe is high.
// - Sixteen bytes per frame, each group of eight bits selects one output.
// - Card slot identity is two bits; only zero, one or two are legal.
// - Act on a byte only when its top two bits equal the slot identity.
// - Low four bits of a byte are the input number within its group.
// - Group code 0,1,2 picks inputs 1-16,17-32,33-48; code 3 means off.
// - Selected input becomes a three-bit modulo-8 chip input address.
// - Six tristate selects, at most one of them asserted per output.
// - Slot mismatch leaves all six tristate selects deasserted for that output.
// - Bit position counter wraps every eight shifted bits.
// - Output index clears while strobe is low, decrements at bit time two.
// - At bit time seven a one-cycle load pulse strobes the crosspoint chips.
// - Each load captures selects and input address at the indexed output.
// - Six circuits of two chips; one feeds outputs 1-8, other 9-16.
`timescale 1ns/1ps

module crosspoint_bitstream_decoder #(
  parameter int OUTPUTS = xpt_decoder_pkg::OUT_COUNT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [xpt_decoder_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  input wire logic control_serial_clock,
  input wire logic control_serial_data,
  input wire logic control_frame_strobe,
  input wire logic [1:0] card_slot_identity,
  output logic load_strobe,
  output logic [5:0] chip_tristate_selects,
  output logic [2:0] chip_input_address,
  output logic [3:0] output_index_address,
  output logic [1:0] chip_bank_select
);

  // ----------------------------------------
  // Link domain reset and level crossings
  // ----------------------------------------
  logic link_rst_meta_q;
  logic link_rst_q;
  logic [1:0] id_meta_q;
  logic [1:0] id_link_q;
  logic enable_meta_q;
  logic enable_link_q;
  logic ctrl_enable_q;

  // Link-side checks all sleep while the link reset stands
  default disable iff (link_rst_q);

  // Reset enters the link domain through two flops; link clock must run in reset
  always_ff @(posedge control_serial_clock) begin
    link_rst_meta_q <= sys_rst;
    link_rst_q <= link_rst_meta_q;
  end

  // Strapped identity and software enable cross as levels
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q) begin
      id_meta_q <= 2'h0;
      id_link_q <= 2'h0;
      enable_meta_q <= xpt_decoder_pkg::CTRL_ENABLE_RESET;
      enable_link_q <= xpt_decoder_pkg::CTRL_ENABLE_RESET;
    end else begin
      id_meta_q <= card_slot_identity;
      id_link_q <= id_meta_q;
      enable_meta_q <= ctrl_enable_q;
      enable_link_q <= enable_meta_q;
    end
  end

  // ----------------------------------------
  // Byte framing on the serial clock
  // ----------------------------------------
  logic [7:0] shift_q;
  logic [2:0] bitpos_q;
  logic [3:0] index_q;
  xpt_decoder_pkg::control_byte_t byte_now;
  xpt_decoder_pkg::route_entry_t route_now;
  logic byte_done;

  // Completed byte as seen on the edge that shifts its last bit, MSB first
  assign byte_now = xpt_decoder_pkg::control_byte_t'({shift_q[6:0], control_serial_data});
  assign byte_done = control_frame_strobe && (bitpos_q == xpt_decoder_pkg::BITPOS_LAST);
  assign route_now = xpt_decoder_pkg::decode_route(byte_now, id_link_q);

  // Shift register only moves while the frame strobe is high
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q) begin
      shift_q <= 8'h00;
    end else if (control_frame_strobe) begin
      shift_q <= {shift_q[6:0], control_serial_data};
    end
  end

  // Bit position restarts with every frame and wraps per byte
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q || !control_frame_strobe) begin
      bitpos_q <= xpt_decoder_pkg::BITPOS_RESET;
    end else begin
      bitpos_q <= bitpos_q + 3'h1;
    end
  end

  // Output index: 0 outside frames, first byte steps it to 15 (output 16)
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q || !control_frame_strobe) begin
      index_q <= xpt_decoder_pkg::INDEX_RESET;
    end else if (bitpos_q == xpt_decoder_pkg::BITPOS_INDEX_STEP) begin
      index_q <= index_q - 4'h1;
    end
  end

  // ----------------------------------------
  // Load strobe and chip address outputs
  // ----------------------------------------
  // A registered one-cycle pulse stands in for the gated inverted clock: gating a
  // clock in logic would glitch, and the chips take data on the pulse's high level.
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q) begin
      load_strobe <= 1'b0;
    end else begin
      load_strobe <= byte_done && enable_link_q;
    end
  end

  // Selects and addresses stand until the next load
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q) begin
      chip_tristate_selects <= 6'h00;
      chip_input_address <= 3'h0;
      output_index_address <= xpt_decoder_pkg::INDEX_RESET;
      chip_bank_select <= 2'h0;
    end else if (byte_done && enable_link_q) begin
      chip_tristate_selects <= route_now.tsel;
      chip_input_address <= route_now.addr;
      output_index_address <= index_q;
      chip_bank_select <= index_q[3] ? 2'h2 : 2'h1;
    end
  end

  // ----------------------------------------
  // Crosspoint latch image in the fabric
  // ----------------------------------------
  xpt_decoder_pkg::route_entry_t route_q [OUTPUTS];

  // Each load latches into the output picked by the index
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q) begin
      for (int i = 0; i < OUTPUTS; i++) begin
        route_q[i] <= xpt_decoder_pkg::ROUTE_RESET;
      end
    end else if (byte_done && enable_link_q) begin
      route_q[index_q] <= route_now;
    end
  end

  // ----------------------------------------
  // Load event crossing to the system clock
  // ----------------------------------------
  xpt_decoder_pkg::load_word_t evt_word_q;
  logic evt_tog_q;

  // Word is held until the next load, eight link clocks later at least
  always_ff @(posedge control_serial_clock) begin
    if (link_rst_q) begin
      evt_word_q <= '0;
      evt_tog_q <= 1'b0;
    end else if (byte_done && enable_link_q) begin
      evt_word_q <= '{index: index_q, entry: route_now};
      evt_tog_q <= ~evt_tog_q;
    end
  end

  logic tog_meta_q;
  logic tog_sync_q;
  logic tog_seen_q;
  logic evt_sys;

  // Toggle synchroniser; the second and third flops feed the edge compare, the first never does
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_seen_q <= 1'b0;
    end else begin
      tog_meta_q <= evt_tog_q;
      tog_sync_q <= tog_meta_q;
      tog_seen_q <= tog_sync_q;
    end
  end

  assign evt_sys = tog_sync_q ^ tog_seen_q;

  // ----------------------------------------
  // System side state
  // ----------------------------------------
  logic [1:0] id_sys_meta_q;
  logic [1:0] id_sys_q;
  xpt_decoder_pkg::load_word_t last_q;
  logic [7:0] load_count_q;
  xpt_decoder_pkg::route_entry_t shadow_q [OUTPUTS];

  // Identity seen by software, two flops from the pin
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      id_sys_meta_q <= 2'h0;
      id_sys_q <= 2'h0;
    end else begin
      id_sys_meta_q <= card_slot_identity;
      id_sys_q <= id_sys_meta_q;
    end
  end

  // Mirror of every load for readback; counter wraps at 256
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_q <= '0;
      load_count_q <= xpt_decoder_pkg::COUNT_RESET;
      for (int i = 0; i < OUTPUTS; i++) begin
        shadow_q[i] <= xpt_decoder_pkg::ROUTE_RESET;
      end
    end else if (evt_sys) begin
      last_q <= evt_word_q;
      load_count_q <= load_count_q + 8'h01;
      shadow_q[evt_word_q.index] <= evt_word_q.entry;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Control register: bit 0 enables loads into the chips
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_enable_q <= xpt_decoder_pkg::CTRL_ENABLE_RESET;
    end else if (reg_wr && (reg_addr == xpt_decoder_pkg::CTRL_OFFSET)) begin
      ctrl_enable_q <= reg_wr_data[xpt_decoder_pkg::CTRL_ENABLE_BIT];
    end
  end

  logic [31:0] rd_d;
  logic [3:0] rd_slot;

  assign rd_slot = reg_addr[5:2];

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (reg_addr == xpt_decoder_pkg::CTRL_OFFSET) begin
      rd_d[xpt_decoder_pkg::CTRL_ENABLE_BIT] = ctrl_enable_q;
    end else if (reg_addr == xpt_decoder_pkg::STATUS_OFFSET) begin
      rd_d[xpt_decoder_pkg::STATUS_SLOT_LSB +: 2] = id_sys_q;
      rd_d[xpt_decoder_pkg::STATUS_LEGAL_BIT] = (id_sys_q <= xpt_decoder_pkg::SLOT_LIMIT);
      rd_d[xpt_decoder_pkg::STATUS_COUNT_LSB +: 8] = load_count_q;
    end else if (reg_addr == xpt_decoder_pkg::LAST_OFFSET) begin
      rd_d[12:0] = last_q;
    end else if ((reg_addr[7:6] == xpt_decoder_pkg::ROUTE_BASE[7:6]) && (reg_addr[1:0] == 2'h0)
                 && (32'(rd_slot) < 32'(OUTPUTS))) begin
      rd_d[8:0] = shadow_q[rd_slot];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rd_data <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rd_data <= rd_d;
    end else begin
      reg_rd_data <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic load_match;
  assign load_match = (byte_now.slot == id_link_q);

  // Framing: shifting, bit position and restart with the strobe
  a_shift_hold_idle: assert property (@(posedge control_serial_clock)
    !control_frame_strobe |=> (shift_q == $past(shift_q)))
    else $error("shift register moved outside the strobe");

  a_shift_in_frame: assert property (@(posedge control_serial_clock)
    control_frame_strobe |=> (shift_q == {$past(shift_q[6:0]), $past(control_serial_data)}))
    else $error("serial bit not shifted in during the strobe");

  a_bitpos_byte_wrap: assert property (@(posedge control_serial_clock)
    (control_frame_strobe && bitpos_q == 3'h7) |=> (bitpos_q == 3'h0))
    else $error("bit position did not wrap after eight bits");

  a_frame_restart: assert property (@(posedge control_serial_clock)
    !control_frame_strobe ##1 control_frame_strobe [*3] |=> (bitpos_q == 3'h3))
    else $error("framing did not restart with the strobe");

  // Output index: cleared outside frames, one step per byte
  a_index_step_down: assert property (@(posedge control_serial_clock)
    (control_frame_strobe && bitpos_q == 3'h2) |=> (index_q == $past(index_q) - 4'h1))
    else $error("output index did not step at bit time two");

  a_index_hold: assert property (@(posedge control_serial_clock)
    (control_frame_strobe && bitpos_q != 3'h2) |=> (index_q == $past(index_q)))
    else $error("output index moved away from bit time two");

  a_index_idle_clear: assert property (@(posedge control_serial_clock)
    !control_frame_strobe |=> (index_q == 4'h0))
    else $error("output index not cleared outside frame");

  a_index_on_load: assert property (@(posedge control_serial_clock)
    (byte_done && enable_link_q) |=> (output_index_address == $past(index_q)))
    else $error("output address does not follow the index at load");

  // Load pulse: one cycle, only inside frames and only when enabled
  a_load_one_cycle: assert property (@(posedge control_serial_clock)
    (byte_done && enable_link_q) |=> load_strobe ##1 !load_strobe)
    else $error("load pulse not exactly one cycle after bit seven");

  a_no_load_idle: assert property (@(posedge control_serial_clock)
    !control_frame_strobe |=> !load_strobe)
    else $error("load pulse outside the frame strobe");

  a_no_load_disabled: assert property (@(posedge control_serial_clock)
    !enable_link_q |=> !load_strobe)
    else $error("load pulse while loads are disabled");

  // Select decode: one-hot, slot gating, group choice and chip address
  a_tsel_one_hot: assert property (@(posedge control_serial_clock)
    $onehot0(chip_tristate_selects))
    else $error("more than one tristate select asserted");

  a_mismatch_no_drive: assert property (@(posedge control_serial_clock)
    (byte_done && enable_link_q && (!load_match || byte_now.group == 2'h3)) |=>
      (chip_tristate_selects == 6'h00))
    else $error("selects asserted for foreign or off byte");

  a_bad_id_no_drive: assert property (@(posedge control_serial_clock)
    (byte_done && enable_link_q && (id_link_q > 2'h2)) |=> (chip_tristate_selects == 6'h00))
    else $error("selects asserted with an illegal card identity");

  a_group_select: assert property (@(posedge control_serial_clock)
    (byte_done && enable_link_q && load_match && (id_link_q <= 2'h2) &&
      (byte_now.group != 2'h3)) |=>
      chip_tristate_selects[$past({byte_now.group, byte_now.input_num[3]})])
    else $error("tristate select does not follow group and input");

  a_addr_mod_eight: assert property (@(posedge control_serial_clock)
    (byte_done && enable_link_q) |=> (chip_input_address == $past(byte_now.input_num[2:0])))
    else $error("chip input address is not the input modulo eight");

  a_route_capture: assert property (@(posedge control_serial_clock)
    load_strobe |-> (route_q[output_index_address] == {chip_tristate_selects, chip_input_address}))
    else $error("load did not capture into the indexed output");

  a_bank_from_index: assert property (@(posedge control_serial_clock)
    load_strobe |-> (chip_bank_select == (output_index_address[3] ? 2'h2 : 2'h1)))
    else $error("chip bank does not match the output half");

  // Main scenarios worth seeing at least once
  c_matched_load: cover property (@(posedge control_serial_clock)
    load_strobe && (chip_tristate_selects != 6'h00));
  c_last_output: cover property (@(posedge control_serial_clock)
    load_strobe && (output_index_address == 4'h0));
  c_cut_frame: cover property (@(posedge control_serial_clock)
    $fell(control_frame_strobe) && (bitpos_q != 3'h0));
  c_disabled_byte: cover property (@(posedge control_serial_clock)
    byte_done && !enable_link_q);
  c_sys_event: cover property (@(posedge clock) disable iff (sys_rst)
    evt_sys && (last_q.index == 4'hF));

endmodule : crosspoint_bitstream_decoder

// ===== dv/combiner_serial_model.sv
// Behavioural model of the combiner processor driving the serial control link.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps

module combiner_serial_model (
  output logic control_serial_clock,
  output logic control_serial_data,
  output logic control_frame_strobe,
  output logic [1:0] card_slot_identity
);
  // ----------------------------------------
  // Link drive
  // ----------------------------------------
  // Clock rests low between calls, so it stands still between task calls
  initial begin
    control_serial_clock = 1'b0;
    control_serial_data = 1'b0;
    control_frame_strobe = 1'b0;
    card_slot_identity = 2'h0;
  end

  // One 15 ns link cycle; data and strobe change while the clock is low
  task automatic tick(input logic stb, input logic d);
    control_frame_strobe = stb;
    control_serial_data = d;
    #7.5 control_serial_clock = 1'b1;
    #7.5 control_serial_clock = 1'b0;
  endtask : tick

  // Strobe low with data toggling, so stray shifts would show
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      tick(1'b0, ~control_serial_data);
    end
  endtask : idle

  // Output 16 first, each byte MSB first, strobe low edge before
  task automatic frame(input logic [7:0] b [16]);
    idle(1);
    for (int o = 0; o < 16; o++) begin
      for (int k = 7; k >= 0; k--) begin
        tick(1'b1, b[o][k]);
      end
    end
    idle(3);
  endtask : frame

  // Truncated byte, abandoned by the next strobe low
  task automatic partial(input logic [7:0] b, input int n);
    for (int k = 7; k > 7 - n; k--) begin
      tick(1'b1, b[k]);
    end
  endtask : partial

  // Identity handed to this card
  task automatic set_id(input logic [1:0] id);
    card_slot_identity = id;
  endtask : set_id
endmodule : combiner_serial_model

// ===== dv/crosspoint_bitstream_decoder_test.sv
// Self-checking bench for the crosspoint bitstream decoder.
// Assumes the package is compiled first and the serial model drives the link.
`timescale 1ns/1ps

module crosspoint_bitstream_decoder_test;
  logic clock;
  logic sys_rst;
  logic [xpt_decoder_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wr_data;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rd_data;
  logic control_serial_clock;
  logic control_serial_data;
  logic control_frame_strobe;
  logic [1:0] card_slot_identity;
  logic load_strobe;
  logic [5:0] chip_tristate_selects;
  logic [2:0] chip_input_address;
  logic [3:0] output_index_address;
  logic [1:0] chip_bank_select;
  logic [14:0] seen [$];
  int errors = 0;
  int tests_run = 0;
  int loads = 0;

  crosspoint_bitstream_decoder uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .control_serial_clock(control_serial_clock), .control_serial_data(control_serial_data),
    .control_frame_strobe(control_frame_strobe), .card_slot_identity(card_slot_identity),
    .load_strobe(load_strobe), .chip_tristate_selects(chip_tristate_selects),
    .chip_input_address(chip_input_address), .output_index_address(output_index_address),
    .chip_bank_select(chip_bank_select));

  combiner_serial_model partner (.control_serial_clock(control_serial_clock),
    .control_serial_data(control_serial_data), .control_frame_strobe(control_frame_strobe),
    .card_slot_identity(card_slot_identity));

  // ----------------------------------------
  // Clock, load monitor and helpers
  // ----------------------------------------
  // 50 MHz system clock
  always #10 clock = ~clock;

  // Mid-cycle capture of every load, where outputs have settled
  always @(negedge control_serial_clock) begin
    if (load_strobe === 1'b1) begin
      seen.push_back({output_index_address, chip_tristate_selects, chip_input_address,
        chip_bank_select});
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Expected selects and chip address; identity 3 never matches
  function automatic logic [8:0] ent(input logic [7:0] b, input logic [1:0] id);
    logic [5:0] ts;
    ts = 6'h00;
    if (b[7:6] == id && id != 2'h3 && b[5:4] != 2'h3) begin
      ts = 6'h01 << {b[5:4], b[3]};
    end
    return {ts, b[2:0]};
  endfunction : ent

  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Full frame: every load word, status count and two route shadows
  task automatic t_frame(input logic [1:0] id, input int salt);
    logic [7:0] b [16];
    logic [31:0] v;
    logic [14:0] e;
    for (int o = 0; o < 16; o++) begin
      b[o] = {2'(o + salt), 2'(o >> 2), 4'(o * 5 + salt)};
    end
    partner.set_id(id);
    repeat (10) @(posedge clock);
    partner.frame(b);
    repeat (10) @(posedge clock);
    check(32'(seen.size()), 32'h10, "load count");
    for (int o = 0; o < 16 && o < seen.size(); o++) begin
      e = {4'(15 - o), ent(b[o], id), ((15 - o) < 8) ? 2'h1 : 2'h2};
      check(32'(seen[o]), 32'(e), "load word");
    end
    seen.delete();
    loads = loads + 16;
    rd(xpt_decoder_pkg::STATUS_OFFSET, v);
    check(v, {16'h0, 8'(loads), 5'h0, id != 2'h3, id}, "status");
    rd(8'h7C, v);
    check(v, {23'h0, ent(b[0], id)}, "route out16");
    rd(8'h40, v);
    check(v, {23'h0, ent(b[15], id)}, "route out1");
    rd(xpt_decoder_pkg::LAST_OFFSET, v);
    check(v, {19'h0, 4'h0, ent(b[15], id)}, "last load");
  endtask : t_frame

  // Reset values and an unmapped read
  task automatic t_regs;
    logic [31:0] v;
    rd(xpt_decoder_pkg::CTRL_OFFSET, v);
    check(v, 32'h1, "ctrl reset");
    // Read data must fall back to zero one cycle after it stood
    @(posedge clock);
    #1;
    check(reg_rd_data, 32'h0, "read data idle");
    rd(8'h10, v);
    check(v, 32'h0, "unmapped");
  endtask : t_regs

  // Disabled card must not load anything
  task automatic t_disable;
    logic [7:0] b [16];
    logic [31:0] v;
    for (int o = 0; o < 16; o++) begin
      b[o] = 8'h42;
    end
    wr(xpt_decoder_pkg::CTRL_OFFSET, 32'h0);
    rd(xpt_decoder_pkg::CTRL_OFFSET, v);
    check(v, 32'h0, "ctrl cleared");
    partner.frame(b);
    check(32'(seen.size()), 32'h0, "disabled loads");
    seen.delete();
    wr(xpt_decoder_pkg::CTRL_OFFSET, 32'h1);
  endtask : t_disable

  // Main sequence; link clock runs during reset so the link side clears
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wr_data = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fork
      partner.idle(10);
      repeat (12) @(posedge clock);
    join
    sys_rst <= 1'b0;
    partner.idle(4);
    t_regs();
    t_frame(2'h1, 0);
    t_frame(2'h0, 1);
    t_frame(2'h2, 2);
    t_frame(2'h3, 3);
    partner.partial(8'hA5, 5);
    t_frame(2'h1, 5);
    t_disable();
    end_of_test();
  end

  // Watchdog well beyond the expected run of about 15 us
  initial begin
    #200000;
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : crosspoint_bitstream_decoder_test
